// File: dlm_map.svh
// register map, field positions, codes and timing figures of the drive link master
// assumes inclusion by name from the package and from the dlm_top module
`ifndef DLM_MAP_SVH
`define DLM_MAP_SVH

// wishbone byte addresses
`define DLM_ADR_SETUP     8'h00
`define DLM_ADR_MASK      8'h04
`define DLM_ADR_CTRL      8'h08
`define DLM_ADR_MON       8'h0c
`define DLM_ADR_STAT      8'h10
`define DLM_ADR_FBK       8'h14

// setup register fields
`define DLM_SU_PROT       0
`define DLM_SU_BAUD_LO    1
`define DLM_SU_BAUD_HI    3
`define DLM_SU_DONE       4
`define DLM_SU_RES_LO     8
`define DLM_SU_RES_HI     15

// control register fields
`define DLM_CT_DRV_LO     0
`define DLM_CT_DRV_HI     4
`define DLM_CT_RUN        8
`define DLM_CT_COAST      9
`define DLM_CT_QUICK      10
`define DLM_CT_FACK       11
`define DLM_CT_DIR        12
`define DLM_CT_SP_LO      16
`define DLM_CT_SP_HI      31

// transmit buffer entry layout
`define DLM_ENT_W         20
`define DLM_ENT_SP_HI     15
`define DLM_ENT_RUN       16
`define DLM_ENT_COAST     17
`define DLM_ENT_QUICK     18
`define DLM_ENT_DIR       19

// control word toward the drive
`define DLM_CW_RUN        0
`define DLM_CW_COAST      1
`define DLM_CW_QUICK      2
`define DLM_CW_FACK       3
`define DLM_CW_CW         4

// drive status word bits
`define DLM_ST_RUNNING    2
`define DLM_ST_FAULT      3
`define DLM_ST_INHIBIT    6
`define DLM_ST_CW         14

// status register flag positions
`define DLM_FL_RUNNING    16
`define DLM_FL_CW         17
`define DLM_FL_INHIBIT    18
`define DLM_FL_FAULT      19

// speed limit in 0.1 percent units
`define DLM_SP_MAX        16'sd2000

// baud rate codes
`define DLM_BAUD_1200     3'd0
`define DLM_BAUD_2400     3'd1
`define DLM_BAUD_4800     3'd2
`define DLM_BAUD_9600     3'd3
`define DLM_BAUD_19200    3'd4
`define DLM_BAUD_RST      3'd3

// longest time between polls per active drive, ms
`define DLM_SLOT_MS_1200  9'd460
`define DLM_SLOT_MS_2400  9'd240
`define DLM_SLOT_MS_4800  9'd130
`define DLM_SLOT_MS_9600  9'd80
`define DLM_SLOT_MS_19200 9'd50

// clock rate
`define DLM_CLK_HZ        25000000
`define DLM_MS_PER_S      1000

// result codes
`define DLM_RES_OK        8'h00
`define DLM_RES_TIMEOUT   8'h01
`define DLM_RES_BAD_BAUD  8'h10
`define DLM_RES_BUSY      8'h11

`endif

// File: dlm_pkg.sv
// types of the drive link master
// assumes dlm_map.svh on the include path
`include "dlm_map.svh"

package dlm_pkg;

   typedef enum logic [4:0] {
      P_IDLE = 5'b00001,
      P_FIND = 5'b00010,
      P_READ = 5'b00100,
      P_SEND = 5'b01000,
      P_WAIT = 5'b10000
   } dlm_poll_e;

   typedef logic [`DLM_ENT_W-1:0] dlm_ent_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        en;
      logic [2:0]  baud;
      logic [31:0] mask;
      logic [31:0] mask_req;
      logic        su_pend;
      logic [3:0]  su_req;
      logic        done;
      logic [7:0]  su_res;
      logic        ct_pend;
      logic [31:0] ct_req;
      logic [31:0] fack_lvl;
      logic [31:0] fack_pend;
      logic [31:0] fault;
      logic [31:0] inhibit;
      logic [4:0]  mon;
      dlm_poll_e   ps;
      logic [4:0]  cur;
      logic [15:0] pre;
      logic [8:0]  slot;
      logic        req;
      logic [4:0]  laddr;
      logic [15:0] lctrl;
      logic [15:0] lsp;
      logic        hv;
      logic [15:0] h_st;
      logic [15:0] h_sp;
      logic [7:0]  h_err;
      logic        strobe;
      logic [15:0] st;
      logic [15:0] sp;
      logic [7:0]  err;
   } dlm_state_s;

   typedef struct packed {
      logic [31:0][`DLM_ENT_W-1:0] arr;
      dlm_ent_t                    rd;
   } dlm_mem_s;

endpackage

// File: dlm_mem_if.sv
// write and read port of the per-drive transmit buffer
// assumes both ends on the same clock
`timescale 1ns/10ps

interface dlm_mem_if;
   import dlm_pkg::*;
   logic     we;
   logic [4:0] waddr;
   dlm_ent_t wdata;
   logic [4:0] raddr;
   dlm_ent_t rdata;

   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: dlm_mem.sv
// transmit buffer: one command entry per drive address, registered read
// assumes a synchronous active high reset and one clock
`timescale 1ns/10ps

module dlm_mem
   import dlm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   dlm_mem_if.mem    mif
);

   dlm_mem_s s_q;
   dlm_mem_s s_d;

   // reset clears every entry so an unwritten drive is told to stop
   always_comb
   begin
      s_d = s_q;
      if (mif.we)
      begin
         s_d.arr[mif.waddr] = mif.wdata;
      end
      s_d.rd = s_q.arr[mif.raddr];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign mif.rdata = s_q.rd;

endmodule // dlm_mem

// File: dlm_top.sv
// drive link master: setup, per-drive commands, background poll, reply outputs
// assumes a classic wishbone master, a one-cycle scan_i per program scan and a
// frame engine outside that turns each link_req_o into a frame and returns replies
//
// Summary of operation
// RQ1: controller completes setup without error before any drive command.
// RQ2: setup finishes in one step; done and result byte come together.
// RQ3: controller pulses the setup enable for one scan per state change.
// RQ4: controller disables the running link before changing setup parameters.
// RQ5: protocol select 1 gives port to drives; 0 returns it, drives off.
// RQ6: baud rate is one of 1200, 2400, 4800, 9600, 19200.
// RQ7: 32-bit mask; bit n set marks drive address n active.
// RQ8: every active drive is polled repeatedly in the background.
// RQ9: controller avoids address 31 for drives that lack it.
// RQ10: control command buffers requests; sent only if address active in mask.
// RQ11: controller uses one control command per drive address.
// RQ12: run request commands run only with stops, fault and lockout clear.
// RQ13: run request at 0 commands a ramp down to standstill.
// RQ14: coast-stop lets motor coast; quick-stop stops it rapidly.
// RQ15: rising fault-clear request is passed to the drive.
// RQ16: rotation select 0 means counterclockwise, 1 means clockwise.
// RQ17: target drive address 0 to 31 selects the receiving drive.
// RQ18: setpoint -200.0 to 200.0 percent; negative reverses rotation.
// RQ19: reply strobe high exactly one scan; outputs refreshed then.
// RQ20: result byte reports outcome of the latest request to that drive.
// RQ21: status output is the drive's raw 16-bit status word.
// RQ22: speed feedback in percent, -200.0 to 200.0.
// RQ23: running flag 1 when drive runs, 0 when stopped.
// RQ24: lockout flag mirrors the drive inhibit state.
// RQ25: poll interval at most 80 ms per active drive at 9600, scaled.
// RQ26: scan strobe sets pulse widths and sampling of requests.
// RQ27: fault-clear is edge detected against its previous value.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "dlm_map.svh"

module dlm_top
   import dlm_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `DLM_CLK_HZ / `DLM_MS_PER_S
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   input  wire logic        scan_i,
   output      logic        link_req_o,
   output      logic [4:0]  link_addr_o,
   output      logic [15:0] link_ctrl_o,
   output      logic [15:0] link_setpoint_o,
   output      logic [2:0]  link_baud_o,
   output      logic        protocol_select_o,
   input  wire logic        link_rsp_valid_i,
   input  wire logic [4:0]  link_rsp_addr_i,
   input  wire logic [15:0] link_rsp_status_i,
   input  wire logic [15:0] link_rsp_speed_i,
   input  wire logic [7:0]  link_rsp_err_i,
   output      logic        setup_done_o,
   output      logic [7:0]  setup_result_o,
   output      logic        reply_strobe_o,
   output      logic [15:0] drive_status_o,
   output      logic [15:0] drive_speed_o,
   output      logic [7:0]  drive_err_o,
   output      logic        running_o,
   output      logic        rotation_flag_o,
   output      logic        lockout_o,
   output      logic        fault_o
);

   dlm_state_s s_q;
   dlm_state_s s_d;
   dlm_mem_if  mif ();

   logic        bus_req;
   logic [31:0] wv;
   dlm_ent_t    ent;
   logic [15:0] spv;
   logic [15:0] mag;
   logic        neg;
   logic [15:0] cw;
   logic [4:0]  drv;
   logic        mem_we;
   logic [4:0]  mem_waddr;
   dlm_ent_t    mem_wdata;

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   // clamp to the +-200.0 percent range, 0.1 percent units
   function automatic logic [15:0] clamp_pct(input logic [15:0] v);
      logic signed [15:0] sv;
      sv = $signed(v);
      if (sv > `DLM_SP_MAX)
      begin
         return `DLM_SP_MAX;
      end
      else if (sv < -`DLM_SP_MAX)
      begin
         return -`DLM_SP_MAX;
      end
      return v;
   endfunction

   function automatic logic [8:0] slot_ms(input logic [2:0] b);
      case (b)
         `DLM_BAUD_1200: return `DLM_SLOT_MS_1200;
         `DLM_BAUD_2400: return `DLM_SLOT_MS_2400;
         `DLM_BAUD_4800: return `DLM_SLOT_MS_4800;
         `DLM_BAUD_9600: return `DLM_SLOT_MS_9600;
         default:        return `DLM_SLOT_MS_19200;
      endcase
   endfunction

   always_comb
   begin
      s_d       = s_q;
      wv        = '0;
      ent       = mif.rdata;
      spv       = '0;
      mag       = '0;
      neg       = 1'b0;
      cw        = '0;
      drv       = s_q.ct_req[`DLM_CT_DRV_HI:`DLM_CT_DRV_LO];
      mem_we    = 1'b0;
      mem_waddr = drv;
      mem_wdata = '0;
      s_d.ack   = 1'b0;
      s_d.req   = 1'b0;
      bus_req   = wb_cyc_i && wb_stb_i && !s_q.ack;

      // bus slave; a write that finds its previous command still waiting is held off
      if (bus_req && !(wb_we_i && wb_adr_i == `DLM_ADR_SETUP && s_q.su_pend)
                  && !(wb_we_i && wb_adr_i == `DLM_ADR_CTRL && s_q.ct_pend))
      begin
         s_d.ack = 1'b1;
         s_d.dat = '0;
         if (wb_adr_i == `DLM_ADR_SETUP)
         begin
            s_d.dat[`DLM_SU_PROT] = s_q.en;
            s_d.dat[`DLM_SU_BAUD_HI:`DLM_SU_BAUD_LO] = s_q.baud;
            s_d.dat[`DLM_SU_DONE] = s_q.done;
            s_d.dat[`DLM_SU_RES_HI:`DLM_SU_RES_LO] = s_q.su_res;
            if (wb_we_i)
            begin
               wv = wmerge({28'h0, s_q.su_req}, wb_dat_i, wb_sel_i);
               s_d.su_req  = wv[3:0];
               s_d.su_pend = 1'b1;
            end
         end
         else if (wb_adr_i == `DLM_ADR_MASK)
         begin
            s_d.dat = s_q.mask_req;
            if (wb_we_i)
            begin
               s_d.mask_req = wmerge(s_q.mask_req, wb_dat_i, wb_sel_i);
            end
         end
         else if (wb_adr_i == `DLM_ADR_CTRL)
         begin
            s_d.dat = s_q.ct_req;
            if (wb_we_i)
            begin
               s_d.ct_req  = wmerge(s_q.ct_req, wb_dat_i, wb_sel_i);
               s_d.ct_pend = 1'b1;
            end
         end
         else if (wb_adr_i == `DLM_ADR_MON)
         begin
            s_d.dat = {27'h0, s_q.mon};
            if (wb_we_i)
            begin
               wv = wmerge({27'h0, s_q.mon}, wb_dat_i, wb_sel_i);
               s_d.mon = wv[4:0];
            end
         end
         else if (wb_adr_i == `DLM_ADR_STAT)
         begin
            s_d.dat = {12'h0, fault_o, lockout_o, rotation_flag_o, running_o, s_q.st};
         end
         else if (wb_adr_i == `DLM_ADR_FBK)
         begin
            s_d.dat = {8'h0, s_q.err, s_q.sp};
         end
      end
      // poller; clears fault-clear pending before the scan logic may set it again
      s_d.hv = s_q.hv && !scan_i; // RQ19
      case (s_q.ps)
         P_IDLE:
         begin
            s_d.cur = '0;
            if (s_q.en)
            begin
               s_d.ps = P_FIND;
            end
         end
         P_FIND:
         begin
            if (!s_q.en)
            begin
               s_d.ps = P_IDLE;
            end
            else if (s_q.mask[s_q.cur]) // RQ10
            begin
               s_d.ps = P_READ;
            end
            else
            begin
               s_d.cur = s_q.cur + 5'd1; // RQ8
            end
         end
         P_READ:
         begin
            s_d.ps = P_SEND;
         end
         P_SEND:
         begin
            spv = ent[`DLM_ENT_SP_HI:0];
            neg = spv[15];
            mag = neg ? 16'(-spv) : spv; // RQ18
            cw[`DLM_CW_RUN] = ent[`DLM_ENT_RUN] && !ent[`DLM_ENT_COAST]
                              && !ent[`DLM_ENT_QUICK] && !s_q.fault[s_q.cur]
                              && !s_q.inhibit[s_q.cur]; // RQ12 RQ13
            cw[`DLM_CW_COAST] = ent[`DLM_ENT_COAST]; // RQ14
            cw[`DLM_CW_QUICK] = ent[`DLM_ENT_QUICK]; // RQ14
            cw[`DLM_CW_FACK]  = s_q.fack_pend[s_q.cur]; // RQ15
            cw[`DLM_CW_CW]    = ent[`DLM_ENT_DIR] ^ neg; // RQ16 RQ18
            s_d.fack_pend[s_q.cur] = 1'b0;
            s_d.req   = 1'b1;
            s_d.laddr = s_q.cur; // RQ17
            s_d.lctrl = cw;
            s_d.lsp   = mag;
            s_d.pre   = '0;
            s_d.slot  = '0;
            s_d.ps    = P_WAIT;
         end
         P_WAIT:
         begin
            if (!s_q.en)
            begin
               s_d.ps = P_IDLE;
            end
            else if (link_rsp_valid_i && link_rsp_addr_i == s_q.cur)
            begin
               s_d.fault[s_q.cur]   = link_rsp_status_i[`DLM_ST_FAULT];
               s_d.inhibit[s_q.cur] = link_rsp_status_i[`DLM_ST_INHIBIT];
               if (s_q.cur == s_q.mon)
               begin
                  s_d.hv    = 1'b1;
                  s_d.h_st  = link_rsp_status_i; // RQ21
                  s_d.h_sp  = clamp_pct(link_rsp_speed_i); // RQ22
                  s_d.h_err = link_rsp_err_i; // RQ20
               end
               s_d.cur = s_q.cur + 5'd1;
               s_d.ps  = P_FIND;
            end
            // one ms of margin is left for the walk to the next active drive
            else if (s_q.slot == slot_ms(s_q.baud) - 9'd1) // RQ25
            begin
               if (s_q.cur == s_q.mon)
               begin
                  s_d.err = `DLM_RES_TIMEOUT; // RQ20
               end
               s_d.cur = s_q.cur + 5'd1;
               s_d.ps  = P_FIND;
            end
            else if (s_q.pre == 16'(MS_CYCLES - 1))
            begin
               s_d.pre  = '0;
               s_d.slot = s_q.slot + 9'd1;
            end
            else
            begin
               s_d.pre = s_q.pre + 16'd1;
            end
         end
         default:
         begin
            s_d.ps = P_IDLE;
         end
      endcase
      // scan boundary: pulses last one scan, pending commands take effect here
      if (scan_i) // RQ26
      begin
         s_d.done   = 1'b0; // RQ2
         s_d.strobe = 1'b0; // RQ19
         if (s_q.su_pend)
         begin
            s_d.su_pend = 1'b0;
            s_d.done    = 1'b1; // RQ2
            if (s_q.su_req[3:1] > `DLM_BAUD_19200) // RQ6
            begin
               s_d.su_res = `DLM_RES_BAD_BAUD;
            end
            else if (s_q.su_req[0] && s_q.en
                     && (s_q.su_req[3:1] != s_q.baud || s_q.mask_req != s_q.mask)) // RQ4
            begin
               s_d.su_res = `DLM_RES_BUSY;
            end
            else
            begin
               s_d.su_res = `DLM_RES_OK;
               s_d.en     = s_q.su_req[0]; // RQ5
               s_d.baud   = s_q.su_req[3:1]; // RQ6
               s_d.mask   = s_q.mask_req; // RQ7
               s_d.req    = s_d.req && s_q.su_req[0]; // RQ5
            end
         end
         if (s_q.ct_pend)
         begin
            s_d.ct_pend = 1'b0;
            mem_we = 1'b1; // RQ10
            mem_wdata[`DLM_ENT_SP_HI:0] = clamp_pct(s_q.ct_req[`DLM_CT_SP_HI:`DLM_CT_SP_LO]); // RQ18
            mem_wdata[`DLM_ENT_RUN]   = s_q.ct_req[`DLM_CT_RUN];
            mem_wdata[`DLM_ENT_COAST] = s_q.ct_req[`DLM_CT_COAST];
            mem_wdata[`DLM_ENT_QUICK] = s_q.ct_req[`DLM_CT_QUICK];
            mem_wdata[`DLM_ENT_DIR]   = s_q.ct_req[`DLM_CT_DIR];
            s_d.fack_lvl[drv] = s_q.ct_req[`DLM_CT_FACK];
            if (s_q.ct_req[`DLM_CT_FACK] && !s_q.fack_lvl[drv]) // RQ27
            begin
               s_d.fack_pend[drv] = 1'b1; // RQ15
            end
         end
         if (s_q.hv)
         begin
            s_d.strobe = 1'b1; // RQ19
            s_d.st     = s_q.h_st;
            s_d.sp     = s_q.h_sp;
            s_d.err    = s_q.h_err;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q      <= '0;
         s_q.baud <= `DLM_BAUD_RST;
         s_q.ps   <= P_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign mif.we    = mem_we;
   assign mif.waddr = mem_waddr;
   assign mif.wdata = mem_wdata;
   assign mif.raddr = s_q.cur;

   dlm_mem u_mem (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .mif   (mif)
   );

   assign wb_dat_o          = s_q.dat;
   assign wb_ack_o          = s_q.ack;
   assign link_req_o        = s_q.req;
   assign link_addr_o       = s_q.laddr;
   assign link_ctrl_o       = s_q.lctrl;
   assign link_setpoint_o   = s_q.lsp;
   assign link_baud_o       = s_q.baud;
   assign protocol_select_o = s_q.en; // RQ5
   assign setup_done_o      = s_q.done;
   assign setup_result_o    = s_q.su_res;
   assign reply_strobe_o    = s_q.strobe;
   assign drive_status_o    = s_q.st;
   assign drive_speed_o     = s_q.sp;
   assign drive_err_o       = s_q.err;
   assign running_o         = s_q.st[`DLM_ST_RUNNING]; // RQ23
   assign rotation_flag_o   = s_q.st[`DLM_ST_CW];
   assign lockout_o         = s_q.st[`DLM_ST_INHIBIT]; // RQ24
   assign fault_o           = s_q.st[`DLM_ST_FAULT];

endmodule // dlm_top

// File: dlm_top_props.sv
// checker for the drive link master top ports
// assumes a bind into dlm_top and one clock domain
`timescale 1ns/10ps
module dlm_top_props
   import dlm_pkg::*;
#(
   parameter int unsigned MS_CYCLES = 10
)
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        scan_i,
   input wire logic        link_req_o,
   input wire logic [15:0] link_ctrl_o,
   input wire logic [15:0] link_setpoint_o,
   input wire logic        protocol_select_o,
   input wire logic        setup_done_o,
   input wire logic        reply_strobe_o,
   input wire logic [15:0] drive_status_o,
   input wire logic        running_o,
   input wire logic        rotation_flag_o,
   input wire logic        lockout_o,
   input wire logic        fault_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence done_close;
      setup_done_o && scan_i;
   endsequence
   sequence strobe_close;
      reply_strobe_o && scan_i;
   endsequence
   done_open_a: assert property ($rose(setup_done_o) |-> $past(scan_i))
      else $error("setup done rose off a scan");
   done_shut_a: assert property (done_close |=> !setup_done_o)
      else $error("setup done longer than one scan");
   strobe_open_a: assert property ($rose(reply_strobe_o) |-> $past(scan_i))
      else $error("reply strobe rose off a scan");
   strobe_shut_a: assert property (strobe_close |=> !reply_strobe_o)
      else $error("reply strobe longer than one scan");
   flag_mirror_a: assert property ($rose(reply_strobe_o) |->
      running_o == drive_status_o[2] && rotation_flag_o == drive_status_o[14]
      && lockout_o == drive_status_o[6] && fault_o == drive_status_o[3])
      else $error("status flags differ from status word");
   req_pulse_a: assert property (link_req_o |=> !link_req_o)
      else $error("poll request wider than one cycle");
   req_enabled_a: assert property (link_req_o |-> protocol_select_o)
      else $error("poll while link disabled");
   run_gate_a: assert property (link_req_o && link_ctrl_o[0] |-> !link_ctrl_o[1] && !link_ctrl_o[2])
      else $error("run sent with a stop request");
   setpoint_range_a: assert property (link_req_o |-> link_setpoint_o <= 16'd2000)
      else $error("setpoint magnitude above limit");
endmodule // dlm_top_props

bind dlm_top dlm_top_props #(.MS_CYCLES(MS_CYCLES)) i_dlm_top_props (
   .clk_i(clk_i), .rst_i(rst_i), .scan_i(scan_i), .link_req_o(link_req_o),
   .link_ctrl_o(link_ctrl_o), .link_setpoint_o(link_setpoint_o),
   .protocol_select_o(protocol_select_o), .setup_done_o(setup_done_o),
   .reply_strobe_o(reply_strobe_o), .drive_status_o(drive_status_o), .running_o(running_o),
   .rotation_flag_o(rotation_flag_o), .lockout_o(lockout_o), .fault_o(fault_o));

// File: dlm_drive_model.sv
// behavioural motor drives on the serial link
// assumes one poll outstanding and the master's clock
`timescale 1ns/10ps
module dlm_drive_model
(
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [4:0]  addr_i,
   input  wire logic [15:0] ctrl_i,
   input  wire logic [15:0] sp_i,
   input  wire logic        fault_set_i,
   input  wire logic        mute_i,
   input  wire logic [7:0]  delay_i,
   output      logic        valid_o = 1'b0,
   output      logic [4:0]  addr_o = 5'h0,
   output      logic [15:0] status_o = 16'h0,
   output      logic [15:0] speed_o = 16'h0,
   output      logic [7:0]  err_o = 8'h0
);
   logic        busy_q = 1'b0;
   logic        fault_q = 1'b0;
   logic [7:0]  cnt_q = 8'h0;
   logic [4:0]  a_q = 5'h0;
   logic [15:0] c_q = 16'h0;
   logic [15:0] s_q = 16'h0;
   always @(posedge clk_i)
   begin
      valid_o <= 1'b0;
      // address, status and speed lines turn over after use, so stale data never looks valid
      if (valid_o)
      begin
         addr_o <= ~addr_o;
         status_o <= ~status_o;
         speed_o <= ~speed_o;
      end
      if (fault_set_i)
         fault_q <= 1'b1;
      if (req_i && !busy_q && !mute_i)
      begin
         busy_q <= 1'b1;
         cnt_q <= delay_i;
         a_q <= addr_i;
         c_q <= ctrl_i;
         s_q <= sp_i;
         if (ctrl_i[3])
            fault_q <= 1'b0;
      end
      else if (busy_q && cnt_q == 8'h0)
      begin
         busy_q <= 1'b0;
         valid_o <= 1'b1;
         addr_o <= a_q;
         err_o <= 8'h00;
         status_o <= {1'b0, c_q[4], 7'h0, fault_q, 2'b0, fault_q, c_q[0], 2'b01};
         speed_o <= c_q[4] ? s_q : -s_q;
      end
      else if (busy_q)
         cnt_q <= cnt_q - 8'h1;
   end
endmodule // dlm_drive_model

// File: dlm_top_tb_top.sv
// self-checking bench for the drive link master
// assumes the design, its checker and the drive model compiled first
`timescale 1ns/10ps
module dlm_top_tb_top;
   import dlm_pkg::*;
   logic        clk_i = 0, rst_i = 1, scan_i = 0, cyc = 0, stb = 0, we = 0;
   logic        fset = 0, mute = 0, ack, req, rv, done, strobe, ps, run, cw, lock, flt;
   logic [7:0]  adr = 0, dly = 8'd40, sres, derr, re;
   logic [31:0] wdat = 0, dat_o, rdat;
   logic [4:0]  la, ra;
   logic [2:0]  lb, sc = 0;
   logic [15:0] lc, lsp, rs, rspd, dst, dspd;
   int          n_mismatch = 0, total_checks = 0;

   dlm_top #(.MS_CYCLES(10)) i_dlm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .scan_i(scan_i), .link_req_o(req), .link_addr_o(la),
      .link_ctrl_o(lc), .link_setpoint_o(lsp), .link_baud_o(lb), .protocol_select_o(ps),
      .link_rsp_valid_i(rv), .link_rsp_addr_i(ra), .link_rsp_status_i(rs),
      .link_rsp_speed_i(rspd), .link_rsp_err_i(re), .setup_done_o(done),
      .setup_result_o(sres), .reply_strobe_o(strobe), .drive_status_o(dst),
      .drive_speed_o(dspd), .drive_err_o(derr), .running_o(run), .rotation_flag_o(cw),
      .lockout_o(lock), .fault_o(flt));
   dlm_drive_model i_dlm_drive_model (.clk_i(clk_i), .req_i(req), .addr_i(la), .ctrl_i(lc),
      .sp_i(lsp), .fault_set_i(fset), .mute_i(mute), .delay_i(dly), .valid_o(rv),
      .addr_o(ra), .status_o(rs), .speed_o(rspd), .err_o(re));

   always #20 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      sc <= sc + 3'd1;
      scan_i <= (sc == 3'd7);
      if (req === 1'b1 && la !== 5'd2)
      begin
         n_mismatch++;
         $display("CHECK FAILED poll address expected 2 seen %0d", la);
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tmo;
      n_mismatch++;
      $display("CHECK FAILED wait expected event seen none");
      finish_test();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      if (g !== e)
         n_mismatch++;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      for (i = 0; i < 100 && ack !== 1'b1; i++)
         @(posedge clk_i);
      if (ack !== 1'b1)
         tmo();
      rdat = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   // 0 done, 1 strobe, 2 poll, 3 timeout code, 5 reply, 6 done low
   task automatic await(input int k);
      int i;
      for (i = 0; i < 3000; i++)
      begin
         @(posedge clk_i);
         #1;
         if (k == 0 && done === 1'b1 || k == 1 && strobe === 1'b1 || k == 2 && req === 1'b1
             || k == 3 && derr === 8'h01 || k == 5 && rv === 1'b1 || k == 6 && done === 1'b0)
            return;
      end
      tmo();
   endtask
   task automatic setup(input logic [3:0] v, input logic [7:0] res);
      await(6);
      wb(1'b1, 8'h00, {28'h0, v});
      await(0);
      chk("setup result", {24'h0, res}, {24'h0, sres});
   endtask

   task automatic t_reset;
      wb(1'b0, 8'h00, 32'h0);
      chk("setup reg", 32'h6, rdat);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rdat);
   endtask
   task automatic t_setup;
      for (int b = 0; b < 5; b++)
      begin
         setup({b[2:0], 1'b0}, 8'h00);
         chk("baud", b, {29'h0, lb});
         chk("port off", 32'h0, {31'h0, ps});
      end
      setup({3'd5, 1'b1}, 8'h10);
      wb(1'b1, 8'h04, 32'h4);
      setup(4'h9, 8'h00);
      chk("port on", 32'h1, {31'h0, ps});
      wb(1'b1, 8'h04, 32'h8);
      setup(4'h9, 8'h11);
      wb(1'b1, 8'h04, 32'h4);
      setup(4'h8, 8'h00);
      setup(4'h9, 8'h00);
   endtask
   task automatic t_run;
      wb(1'b1, 8'h0c, 32'h2);
      await(2);
      wb(1'b1, 8'h08, 32'hfe0c_1102);
      await(2);
      chk("ctrl", 32'h01, {27'h0, lc[4:0]});
      chk("setpoint", 32'h1f4, {16'h0, lsp});
      await(5);
      await(1);
      chk("status", 32'h5, {16'h0, dst});
      chk("speed", 32'hfe0c, {16'h0, dspd});
      chk("flags", 32'h1, {30'h0, cw, run});
      for (int k = 9; k < 11; k++)
      begin
         await(2);
         wb(1'b1, 8'h08, 32'h01f4_1102 | (32'h1 << k));
         await(2);
         chk("stop ctrl", {27'h0, 2'b10, k == 10, k == 9, 1'b0}, {27'h0, lc[4:0]});
      end
   endtask
   task automatic t_fault;
      fset <= 1'b1;
      @(posedge clk_i);
      fset <= 1'b0;
      await(2);
      await(5);
      await(1);
      chk("fault", 32'h1, {31'h0, flt});
      chk("lockout", 32'h1, {31'h0, lock});
      await(2);
      wb(1'b1, 8'h08, 32'h01f4_1102);
      await(2);
      chk("run gated", 32'h0, {31'h0, lc[0]});
      wb(1'b1, 8'h08, 32'h01f4_1802);
      await(2);
      chk("fault clear", 32'h1, {31'h0, lc[3]});
      await(2);
      chk("clear once", 32'h0, {31'h0, lc[3]});
      await(5);
      await(1);
      chk("fault gone", 32'h0, {31'h0, flt});
   endtask
   task automatic t_timeout;
      mute <= 1'b1;
      await(3);
      chk("err timeout", 32'h1, {24'h0, derr});
      mute <= 1'b0;
      await(5);
      await(1);
      chk("err ok", 32'h0, {24'h0, derr});
   endtask
   initial
   begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_setup();
      t_run();
      t_fault();
      t_timeout();
      finish_test();
   end
endmodule // dlm_top_tb_top
